// ---- core/asc_consts.vh ----
// Constants for the serial converter control block: fields, timing and reset values.
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// --------------------------------------------------------------------------
// Control byte field positions
// --------------------------------------------------------------------------
`define ASC_BIT_START 7
`define ASC_BIT_SEL_HI 6
`define ASC_BIT_SEL_MID 5
`define ASC_BIT_SEL_LO 4
`define ASC_BIT_POLARITY 3
`define ASC_BIT_INPUT_CFG 2
`define ASC_BIT_POWER 1
`define ASC_BIT_CONV_CLK 0

// --------------------------------------------------------------------------
// Sequencing counts on serial clock edges
// --------------------------------------------------------------------------
`define ASC_CTRL_BITS 4'd8
`define ASC_TRACK_BIT 4'd6
`define ASC_STROBE_FALLS 4'd2
`define ASC_EXT_LAST_FALL 4'd9
`define ASC_INT_MSB_FALL 2'd2

// --------------------------------------------------------------------------
// Internal conversion oscillator, derived from the core clock
// --------------------------------------------------------------------------
`define ASC_CORE_CLK_KHZ 125000
`define ASC_OSC_KHZ 400
`define ASC_OSC_DIV ((`ASC_CORE_CLK_KHZ + `ASC_OSC_KHZ - 1) / `ASC_OSC_KHZ)

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
// Power-up state is internal clock mode and fully operational.
`define ASC_RST_CONFIG 8'h02
`define ASC_RST_STROBE 1'b1

`endif

// ---- core/asc_core.v ----
// Serial control, track/hold sequencing, result shifting and result FIFO of the converter.
`timescale 1ns/100ps
`default_nettype none
`include "asc_consts.vh"

// --------------------------------------------------------------------------
// Result FIFO
// --------------------------------------------------------------------------
// Flip-flop storage FIFO, valid/ready on both sides.
module asc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire arst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write; no reset needed on the data words.
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // asc_fifo

// --------------------------------------------------------------------------
// Converter control top
// --------------------------------------------------------------------------
module asc_core #(
    parameter FOUR_CHANNEL = 0,
    parameter FIFO_DEPTH = 16
) (
    input wire core_clk,
    input wire arst_n,
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire din_pin,
    output reg dout,
    output reg dout_oe_n,
    output reg conv_strobe,
    output reg conv_strobe_oe_n,
    input wire power_pin_low,
    input wire power_pin_high,
    input wire comp_hi,
    input wire input_negative,
    output reg [7:0] sar_trial,
    output reg track,
    output reg hold,
    output reg [2:0] pos_channel,
    output reg [2:0] neg_channel,
    output reg neg_is_common,
    output reg power_down,
    output reg ref_disable,
    output reg overrun,
    output wire res_valid,
    input wire res_ready,
    output wire [7:0] res_data
);
    localparam integer OSC_DIV_FULL = `ASC_OSC_DIV;
    localparam [8:0] OSC_DIV = OSC_DIV_FULL[8:0];
    // Conversion engine states.
    localparam [1:0] CV_IDLE = 2'd0;
    localparam [1:0] CV_EXT = 2'd1;
    localparam [1:0] CV_INT = 2'd2;
    localparam [1:0] CV_PUSH = 2'd3;

    // One SAR step: keep or drop the trial bit, then try the next lower bit.
    function [7:0] sar_step;
        input [7:0] trial;
        input [2:0] idx;
        input cmp;
        reg [7:0] t;
        begin
            t = trial;
            if (!cmp) begin
                t[idx] = 1'b0;
            end
            if (idx != 3'd0) begin
                t[idx - 3'd1] = 1'b1;
            end
            sar_step = t;
        end
    endfunction

    // Channel code from the three select bits (only hi and mid when FOUR_CHANNEL); the negative side is its pair partner.
    function [2:0] chan_of;
        input hi;
        input mid;
        input lo;
        begin
            chan_of = (FOUR_CHANNEL != 0) ? {1'b0, mid, hi} : {mid, lo, hi};
        end
    endfunction

    // ----------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------------
    reg [1:0] cs_meta;
    reg [1:0] sclk_meta;
    reg [1:0] din_meta;
    reg [1:0] plo_meta;
    reg [1:0] phi_meta;
    reg [1:0] cmp_meta;
    reg [1:0] neg_meta;
    reg sclk_prev;
    reg cs_prev;
    wire cs_n = cs_meta[1];
    wire din = din_meta[1];
    wire sclk_rise = sclk_meta[1] && !sclk_prev;
    wire sclk_fall = !sclk_meta[1] && sclk_prev;
    wire cs_rise = cs_n && !cs_prev;

    // Two flops per pin; only the second stage is read by logic.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_meta <= 2'h3;
            sclk_meta <= 2'h0;
            din_meta <= 2'h0;
            plo_meta <= 2'h0;
            phi_meta <= 2'h0;
            cmp_meta <= 2'h0;
            neg_meta <= 2'h0;
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= {cs_meta[0], cs_n_pin};
            sclk_meta <= {sclk_meta[0], sclk_pin};
            din_meta <= {din_meta[0], din_pin};
            plo_meta <= {plo_meta[0], power_pin_low};
            phi_meta <= {phi_meta[0], power_pin_high};
            cmp_meta <= {cmp_meta[0], comp_hi};
            neg_meta <= {neg_meta[0], input_negative};
            sclk_prev <= sclk_meta[1];
            cs_prev <= cs_meta[1];
        end
    end

    // ----------------------------------------------------------------------
    // Internal oscillator enable
    // ----------------------------------------------------------------------
    reg [8:0] osc_cnt;
    reg osc_tick;

    // Divides the core clock down to the internal conversion rate.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt <= 9'h000;
            osc_tick <= 1'b0;
        end else if (!hold) begin
            // Restarted at every hold, so the first decision waits a full period
            // for the comparator to settle on the first trial code.
            osc_cnt <= 9'h000;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= (osc_cnt == OSC_DIV - 9'h001);
            osc_cnt <= (osc_cnt == OSC_DIV - 9'h001) ? 9'h000 : osc_cnt + 9'h001;
        end
    end

    // ----------------------------------------------------------------------
    // Control byte receiver, track/hold and conversion sequencing
    // ----------------------------------------------------------------------
    reg [7:0] rx_sr;
    reg [3:0] rx_cnt;
    reg rx_armed;
    reg [7:0] config_q;
    reg [1:0] cv_state;
    reg [3:0] ext_fall;
    reg [2:0] bit_idx;
    reg neg_flag;
    reg [7:0] result;
    reg [7:0] out_sr;
    reg [1:0] msb_wait;
    reg out_wait;
    reg push_valid;
    wire push_ready;
    wire ext_mode = config_q[`ASC_BIT_CONV_CLK];
    wire unipolar = config_q[`ASC_BIT_POLARITY];
    wire tri_level_power_pin = plo_meta[1];
    wire decide_now = (cv_state == CV_EXT) && sclk_fall && (ext_fall >= `ASC_STROBE_FALLS - 4'd1);
    // polarity and clamp
    // Result bit as presented: two's complement in bipolar, zero for negative unipolar input.
    wire out_bit = (unipolar && neg_flag) ? 1'b0 :
                   ((!unipolar && bit_idx == 3'd7) ? !cmp_meta[1] : cmp_meta[1]);
    wire [7:0] final_code = (unipolar && neg_flag) ? 8'h00 :
                            (unipolar ? sar_step(sar_trial, 3'd0, cmp_meta[1]) :
                             sar_step(sar_trial, 3'd0, cmp_meta[1]) ^ 8'h80);

    // Main sequencer: receiver and external conversion advance on synchronised serial clock edges, internal conversion on the oscillator enable.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_sr <= 8'h00;
            rx_cnt <= 4'h0;
            rx_armed <= 1'b1;
            config_q <= `ASC_RST_CONFIG;
            cv_state <= CV_IDLE;
            ext_fall <= 4'h0;
            bit_idx <= 3'h7;
            neg_flag <= 1'b0;
            result <= 8'h00;
            out_sr <= 8'h00;
            msb_wait <= 2'h0;
            out_wait <= 1'b0;
            push_valid <= 1'b0;
            sar_trial <= 8'h80;
            track <= 1'b0;
            hold <= 1'b0;
            pos_channel <= 3'h0;
            neg_channel <= 3'h0;
            neg_is_common <= 1'b1;
            dout <= 1'b0;
            conv_strobe <= `ASC_RST_STROBE;
            overrun <= 1'b0;
        end else if (tri_level_power_pin) begin
            rx_cnt <= 4'h0;
            rx_armed <= 1'b1;
            cv_state <= CV_IDLE;
            track <= 1'b0;
            hold <= 1'b0;
            push_valid <= 1'b0;
        end else begin
            if (push_valid && push_ready) begin
                push_valid <= 1'b0;
            end
            if (cs_rise) begin
                rx_cnt <= 4'h0;
                rx_armed <= 1'b1;
                track <= 1'b0;
                if (cv_state == CV_EXT) begin
                    cv_state <= CV_IDLE;
                    hold <= 1'b0;
                end
            end
            if (sclk_rise && !cs_n) begin
                if (rx_cnt == 4'h0) begin
                    if (din && rx_armed) begin
                        rx_sr <= 8'h01;
                        rx_cnt <= 4'h1;
                        rx_armed <= 1'b0;
                    end
                end else if (rx_cnt != `ASC_CTRL_BITS) begin
                    rx_sr <= {rx_sr[6:0], din};
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == `ASC_CTRL_BITS - 4'h1) begin
                        config_q <= {rx_sr[6:0], din};
                    end
                end
            end
            if (sclk_fall && !cs_n) begin
                if (rx_cnt == `ASC_TRACK_BIT) begin
                    track <= 1'b1;
                    hold <= 1'b0;
                    pos_channel <= chan_of(rx_sr[`ASC_BIT_SEL_HI - 2],
                                           rx_sr[`ASC_BIT_SEL_MID - 2],
                                           rx_sr[`ASC_BIT_SEL_LO - 2]);
                    neg_channel <= chan_of(rx_sr[`ASC_BIT_SEL_HI - 2],
                                           rx_sr[`ASC_BIT_SEL_MID - 2],
                                           rx_sr[`ASC_BIT_SEL_LO - 2]) ^ 3'h1;
                    neg_is_common <= rx_sr[0];
                end
                if (rx_cnt == `ASC_CTRL_BITS) begin
                    rx_cnt <= 4'h0;
                    track <= 1'b0;
                    hold <= 1'b1;
                    neg_flag <= neg_meta[1];
                    sar_trial <= 8'h80;
                    bit_idx <= 3'h7;
                    ext_fall <= 4'h0;
                    msb_wait <= 2'h0;
                    out_wait <= 1'b0;
                    // clock source; strobe high; strobe low
                    if (config_q[`ASC_BIT_CONV_CLK]) begin
                        cv_state <= CV_EXT;
                        conv_strobe <= 1'b1;
                    end else begin
                        cv_state <= CV_INT;
                        conv_strobe <= 1'b0;
                    end
                end
            end
            // External mode: one decision per serial fall after the strobe pulse.
            if ((cv_state == CV_EXT) && sclk_fall && !(rx_cnt == `ASC_CTRL_BITS && !cs_n)) begin
                ext_fall <= ext_fall + 4'h1;
                if (ext_fall == `ASC_STROBE_FALLS - 4'd1) begin
                    conv_strobe <= 1'b0;
                end
                if (decide_now) begin
                    dout <= out_bit;
                    sar_trial <= sar_step(sar_trial, bit_idx, cmp_meta[1]);
                    bit_idx <= bit_idx - 3'h1;
                    if (bit_idx == 3'h7) begin
                        rx_armed <= 1'b1;
                    end
                    if (ext_fall == `ASC_EXT_LAST_FALL - 4'd1) begin
                        result <= final_code;
                        cv_state <= CV_IDLE;
                        hold <= 1'b0;
                        push_valid <= 1'b1;
                        // No way to stall the host's clock, so a result arriving while one still waits for room is flagged.
                        overrun <= overrun | (push_valid && !push_ready);
                    end
                end
            end else if ((cv_state != CV_EXT) && sclk_fall && !cs_n && !out_wait) begin
                if (msb_wait == 2'h0) begin
                    dout <= out_sr[7];
                    out_sr <= {out_sr[6:0], 1'b0};
                end else begin
                    msb_wait <= msb_wait - 2'h1;
                    if (msb_wait == 2'h1) begin
                        dout <= out_sr[7];
                        out_sr <= {out_sr[6:0], 1'b0};
                        rx_armed <= 1'b1;
                    end
                end
            end
            // Internal mode: decisions paced by the oscillator enable.
            if ((cv_state == CV_INT) && osc_tick && !(sclk_fall && rx_cnt == `ASC_CTRL_BITS)) begin
                sar_trial <= sar_step(sar_trial, bit_idx, cmp_meta[1]);
                bit_idx <= bit_idx - 3'h1;
                if (bit_idx == 3'h0) begin
                    result <= final_code;
                    hold <= 1'b0;
                    cv_state <= CV_PUSH;
                end
            end
            // Completion waits for FIFO room, so back-pressure holds the strobe low.
            if ((cv_state == CV_PUSH) && !push_valid) begin
                if (push_ready) begin
                    push_valid <= 1'b1;
                    conv_strobe <= 1'b1;
                    out_sr <= result;
                    msb_wait <= `ASC_INT_MSB_FALL;
                    out_wait <= 1'b0;
                    cv_state <= CV_IDLE;
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // Output enables and power state
    // ----------------------------------------------------------------------
    // Enables are low while driving; registered so the pins stay glitch free.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_oe_n <= 1'b1;
            conv_strobe_oe_n <= 1'b0;
            power_down <= 1'b0;
            ref_disable <= 1'b0;
        end else begin
            dout_oe_n <= cs_n;
            conv_strobe_oe_n <= cs_n && ext_mode;
            power_down <= tri_level_power_pin || !config_q[`ASC_BIT_POWER];
            ref_disable <= phi_meta[1] && !tri_level_power_pin;
        end
    end

    // ----------------------------------------------------------------------
    // Result FIFO toward the user side
    // ----------------------------------------------------------------------
    asc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(result),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
endmodule // asc_core
`default_nettype wire

// ---- test/asc_core_asserts.sv ----
// Concurrent checks on the converter control ports.
`timescale 1ns/100ps
`default_nettype none
module asc_core_asserts (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic power_pin_low,
    input wire logic power_pin_high,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic conv_strobe,
    input wire logic conv_strobe_oe_n,
    input wire logic track,
    input wire logic hold,
    input wire logic power_down,
    input wire logic ref_disable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------
    // Pin and sequencing checks
    // ----------------------------------------------------------------
    // Pin sync plus output register take three cycles, so six is safe.
    chk_dout_tristate: assert property (cs_n_pin [*6] |-> dout_oe_n)
        else $error("dout driven while deselected");
    chk_strobe_driven: assert property ((!cs_n_pin) [*6] |-> !conv_strobe_oe_n)
        else $error("strobe released while selected");
    chk_track_hold_excl: assert property (!(track && hold))
        else $error("track and hold both on");
    chk_track_to_hold: assert property ($rose(track) |-> ##[36:44] $rose(hold))
        else $error("acquisition not two serial periods");
    chk_dout_on_fall: assert property ($changed(dout) && !dout_oe_n && !$past(dout_oe_n)
        |-> !sclk_pin)
        else $error("dout moved while serial clock high");
    chk_strobe_pulse: assert property ($rose(hold) && conv_strobe
        |-> ##30 conv_strobe ##20 !conv_strobe)
        else $error("strobe pulse not two periods");
    chk_strobe_fall: assert property ($fell(conv_strobe) |-> hold)
        else $error("strobe fell outside a conversion");
    chk_pin_low_off: assert property (power_pin_low [*4] |-> power_down)
        else $error("power pin low did not power down");
    chk_pin_high_ref: assert property ((power_pin_high && !power_pin_low) [*4]
        |-> ref_disable)
        else $error("power pin high kept reference on");
endmodule // asc_core_asserts

bind asc_core asc_core_asserts u_chk (
    .core_clk(core_clk), .arst_n(arst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .power_pin_low(power_pin_low), .power_pin_high(power_pin_high), .dout(dout),
    .dout_oe_n(dout_oe_n), .conv_strobe(conv_strobe), .conv_strobe_oe_n(conv_strobe_oe_n),
    .track(track), .hold(hold), .power_down(power_down), .ref_disable(ref_disable)
);
`default_nettype wire

// ---- test/asc_host_model.sv ----
// Serial master model that frames control bytes and reads results.
`timescale 1ns/100ps
`default_nettype none
module asc_host_model (
    input wire logic core_clk,
    input wire logic dout,
    input wire logic dout_oe_n,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic din_pin
);
    logic prev;
    // A released result line shows the inverse of its last driven value.
    wire logic sdo = dout_oe_n ? ~prev : dout;
    // Serial clock stands low between frames.
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        din_pin = 1'b0;
        prev = 1'b0;
    end
    always @(posedge core_clk) begin
        if (!dout_oe_n) begin
            prev <= dout;
        end
    end
    task automatic sel(input logic v);
        cs_n_pin = v;
        repeat (10) @(negedge core_clk);
    endtask
    // data settles before rise, even duty
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din_pin = tx[i];
            repeat (10) @(negedge core_clk);
            sclk_pin = 1'b1;
            rx[i] = sdo;
            repeat (10) @(negedge core_clk);
            sclk_pin = 1'b0;
        end
    endtask
endmodule // asc_host_model
`default_nettype wire

// ---- test/asc_core_tb.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module asc_core_tb;
    logic core_clk, arst_n, power_pin_low, power_pin_high, comp_hi, input_negative, res_ready;
    wire cs_n_pin, sclk_pin, din_pin, dout, dout_oe_n, conv_strobe, conv_strobe_oe_n;
    wire track, hold, neg_is_common, power_down, ref_disable, overrun, res_valid;
    wire [7:0] sar_trial, res_data;
    wire [2:0] pos_channel, neg_channel;
    logic [7:0] ain, rx, r2, r3;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    asc_core u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n), .conv_strobe(conv_strobe),
        .conv_strobe_oe_n(conv_strobe_oe_n), .power_pin_low(power_pin_low),
        .power_pin_high(power_pin_high), .comp_hi(comp_hi), .input_negative(input_negative),
        .sar_trial(sar_trial), .track(track), .hold(hold), .pos_channel(pos_channel),
        .neg_channel(neg_channel), .neg_is_common(neg_is_common), .power_down(power_down),
        .ref_disable(ref_disable), .overrun(overrun), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data)
    );
    asc_host_model u_host (
        .core_clk(core_clk), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin), .din_pin(din_pin)
    );
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Comparator model: the held sample is the code ain.
    always @(negedge core_clk) begin
        comp_hi <= (ain >= sar_trial);
    end
    // Roughly twice the expected run length.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One framed conversion: leading zeros, control byte, two read bytes.
    task automatic conv(input logic [7:0] c, input logic [7:0] e);
        int n;
        u_host.sel(1'b0);
        u_host.xfer(8'h00, rx);
        u_host.xfer(c, rx);
        n = 0;
        // The strobe answers the last fall only after the pin synchronisers.
        if (!c[0]) begin
            repeat (4) @(negedge core_clk);
            check("strobe low", conv_strobe, 1'b0);
        end
        while (!c[0] && conv_strobe !== 1'b1 && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        if (!c[0]) check("strobe high", conv_strobe, 1'b1);
        u_host.xfer(8'h00, r2);
        u_host.xfer(8'h00, r3);
        check("result", {r2, r3}, {2'b00, e, 6'h00});
        u_host.sel(1'b1);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        power_pin_low = 1'b0;
        power_pin_high = 1'b0;
        input_negative = 1'b0;
        res_ready = 1'b1;
        comp_hi = 1'b0;
        ain = 8'h5a;
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        u_host.sel(1'b0);
        u_host.xfer(8'h07, rx);
        u_host.sel(1'b1);
        // Every select code, differential then single-ended.
        for (int k = 0; k < 16; k++) begin
            ain = 8'h30 + 8'(k * 9);
            conv({1'b1, k[2:0], 1'b1, k[3], 2'b11}, ain);
            check("pos", pos_channel, {k[1], k[0], k[2]});
            if (k[3]) check("neg com", neg_is_common, 1'b1);
            else check("neg", {neg_is_common, neg_channel}, {1'b0, k[1], k[0], ~k[2]});
        end
        conv(8'h8e, ain);
        check("power", power_down, 1'b0);
        conv(8'h83, ain ^ 8'h80);
        input_negative = 1'b1;
        conv(8'h8b, 8'h00);
        input_negative = 1'b0;
        // Buffer fills with the reader stalled, refuses, then drains.
        res_ready = 1'b0;
        // The seventeenth word waits for room; only the eighteenth finds one pending.
        repeat (17) conv(8'hff, ain);
        check("no overrun", overrun, 1'b0);
        conv(8'hff, ain);
        check("overrun", overrun, 1'b1);
        for (int k = 0; k < 16; k++) begin
            check("fifo", {res_valid, res_data}, {1'b1, ain});
            res_ready = 1'b1;
            @(negedge core_clk);
            res_ready = 1'b0;
        end
        // Reset in mid-run clears the sticky flag and the buffer; the strobe idles high.
        arst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check("reset", {overrun, res_valid, conv_strobe}, 3'b001);
        conv(8'hff, ain);
        // pin high turns off the reference only, pin low powers down
        power_pin_high = 1'b1;
        repeat (6) @(negedge core_clk);
        check("ref off", {ref_disable, power_down}, 2'b10);
        power_pin_high = 1'b0;
        power_pin_low = 1'b1;
        repeat (6) @(negedge core_clk);
        check("pin down", power_down, 1'b1);
        wrap_up();
    end
endmodule // asc_core_tb
`default_nettype wire
